// >>> acc_adc_control.v
// Conversion control for the 8-bit successive-approximation converter
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.vh"

module acc_adc_control #(
  parameter CONV_PERIODS = `ACC_CONV_PERIODS
) (
  input  wire                   core_clk_in,
  input  wire                   rst_n_in,
  input  wire [`ACC_ADDR_W-1:0] bus_addr_in,
  input  wire [7:0]             bus_wdata_in,
  input  wire                   bus_wr_in,
  input  wire                   bus_rd_in,
  output reg  [7:0]             bus_rdata_out,
  input  wire                   power_down_in,
  input  wire [7:0]             sar_data_in,
  output reg  [1:0]             input_select_field_out,
  output reg                    converter_enable_bit_out,
  output reg                    reference_on_out,
  output reg                    sar_sample_out,
  output reg                    irq_out
);

  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_DONE = 2'b10;

  // Index of the last secondary period, cut to the counter width on purpose
  localparam [31:0] CONV_LAST_W = CONV_PERIODS - 1;
  localparam [7:0]  CONV_LAST   = CONV_LAST_W[7:0];

  // Sticky events: conversion done and conversion aborted
  localparam NUM_EVT = 2;

  // Power-down pin comes from another block's domain
  reg                pd_meta_r;
  reg                pd_sync_r;

  // Conversion sequencer
  reg [1:0]          state_r;
  reg [1:0]          state_nxt;
  reg                busy_r;
  reg                busy_nxt;
  reg                done_r;
  reg                done_nxt;
  reg [7:0]          period_cnt_r;
  reg [7:0]          period_cnt_nxt;
  reg [7:0]          result_r;
  reg [7:0]          result_nxt;

  // Secondary peripheral clock divider
  reg [7:0]          div_r;
  reg [7:0]          div_nxt;
  reg [7:0]          div_cnt_r;
  reg [7:0]          div_cnt_nxt;
  reg                tick_r;
  reg                tick_nxt;

  // Software-owned fields
  reg                enable_r;
  reg                enable_nxt;
  reg [1:0]          sel_r;
  reg [1:0]          sel_nxt;
  reg [1:0]          irq_mask_r;
  reg [1:0]          irq_mask_nxt;
  reg [2:0]          irq_level_r;
  reg [2:0]          irq_level_nxt;
  reg                sw_pdown_r;
  reg                sw_pdown_nxt;

  // Interrupt status, read data and output next values
  reg [NUM_EVT-1:0]  irq_stat_r;
  reg [7:0]          rdata_nxt;
  reg [1:0]          sel_out_nxt;
  reg                enable_out_nxt;
  reg                ref_on_nxt;
  reg                sample_nxt;
  reg                irq_nxt;

  // Address decode
  wire               hit_ctrl   = (bus_addr_in == `ACC_CTRL_ADDR);
  wire               hit_result = (bus_addr_in == `ACC_RESULT_ADDR);
  wire               hit_stat   = (bus_addr_in == `ACC_IRQ_STAT_ADDR);
  wire               hit_mask   = (bus_addr_in == `ACC_IRQ_MASK_ADDR);
  wire               hit_level  = (bus_addr_in == `ACC_IRQ_LEVEL_ADDR);
  wire               hit_pdown  = (bus_addr_in == `ACC_PDOWN_ADDR);
  wire               hit_div    = (bus_addr_in == `ACC_SCLK_DIV_ADDR);

  // Write strobes per register; the result register has none
  wire               wr_ctrl    = bus_wr_in && hit_ctrl;
  wire               wr_stat    = bus_wr_in && hit_stat;
  wire               wr_mask    = bus_wr_in && hit_mask;
  wire               wr_level   = bus_wr_in && hit_level;
  wire               wr_pdown   = bus_wr_in && hit_pdown;
  wire               wr_div     = bus_wr_in && hit_div;

  // Conversion control terms
  wire               pdown      = pd_sync_r | sw_pdown_r;
  wire               start_req  = wr_ctrl && bus_wdata_in[`ACC_BUSY_BIT];
  // Enable and start may arrive in the same write
  wire               start_en   = bus_wdata_in[`ACC_EN_BIT];
  wire               start_ok   = start_req && start_en && !busy_r && !done_r && !pdown;
  wire               done_clr   = wr_ctrl && !bus_wdata_in[`ACC_DONE_BIT];
  wire               converting = (state_r == ST_CONV);
  wire               last_tick  = tick_r && (period_cnt_r == CONV_LAST);
  wire               abort      = converting && (pdown || !enable_r);
  wire               finish     = converting && last_tick && !abort;
  wire               irq_pending = (irq_level_r != 3'h0) && ((irq_stat_r & irq_mask_r) != 2'b00);

  // Event set and clear vectors
  wire [NUM_EVT-1:0] evt_set;
  wire [NUM_EVT-1:0] evt_clr;
  wire [7:0]         ctrl_view;

  assign evt_set[`ACC_IRQ_DONE_BIT]  = finish;
  assign evt_set[`ACC_IRQ_ABORT_BIT] = abort;
  assign evt_clr   = wr_stat ? bus_wdata_in[NUM_EVT-1:0] : {NUM_EVT{1'b0}};
  assign ctrl_view = {1'b0, enable_r, 1'b0, done_r, busy_r, 1'b0, sel_r};

  // Two-flop synchroniser; only the second stage feeds logic
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pd_meta_r <= 1'b0;
      pd_sync_r <= 1'b0;
    end else begin
      pd_meta_r <= power_down_in;
      pd_sync_r <= pd_meta_r;
    end
  end

  // Secondary clock as a one-cycle enable, counted only while converting
  always @* begin
    div_cnt_nxt = div_cnt_r;
    tick_nxt    = 1'b0;
    if (!converting) begin
      div_cnt_nxt = 8'h00;
    end else if (div_cnt_r >= div_r) begin
      div_cnt_nxt = 8'h00;
      tick_nxt    = 1'b1;
    end else begin
      div_cnt_nxt = div_cnt_r + 8'h01;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
    end
  end

  // Sequencer next state
  always @* begin
    state_nxt      = state_r;
    busy_nxt       = busy_r;
    done_nxt       = done_r;
    period_cnt_nxt = period_cnt_r;
    result_nxt     = result_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt      = ST_CONV;
          busy_nxt       = 1'b1;
          period_cnt_nxt = 8'h00;
        end
      end
      ST_CONV: begin
        if (abort) begin
          state_nxt = ST_IDLE;
          busy_nxt  = 1'b0;
        end else if (finish) begin
          state_nxt  = ST_DONE;
          busy_nxt   = 1'b0;
          done_nxt   = 1'b1;
          result_nxt = sar_data_in;
        end else if (tick_r) begin
          period_cnt_nxt = period_cnt_r + 8'h01;
        end
      end
      ST_DONE: begin
        if (done_clr) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        busy_nxt  = 1'b0;
        done_nxt  = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= busy_nxt;
      done_r  <= done_nxt;
    end
  end

  // Counter and result only move inside a conversion
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_cnt_r <= 8'h00;
      result_r     <= 8'h00;
    end else begin
      period_cnt_r <= period_cnt_nxt;
      result_r     <= result_nxt;
    end
  end

  // Software writes
  always @* begin
    enable_nxt    = enable_r;
    sel_nxt       = sel_r;
    irq_mask_nxt  = irq_mask_r;
    irq_level_nxt = irq_level_r;
    sw_pdown_nxt  = sw_pdown_r;
    div_nxt       = div_r;
    if (wr_ctrl) begin
      enable_nxt = bus_wdata_in[`ACC_EN_BIT];
      if (!done_r && !busy_r) begin
        sel_nxt = bus_wdata_in[`ACC_SEL_MSB:`ACC_SEL_LSB];
      end
    end
    if (wr_mask) begin
      irq_mask_nxt = bus_wdata_in[1:0];
    end
    if (wr_level) begin
      irq_level_nxt = bus_wdata_in[2:0];
    end
    if (wr_pdown) begin
      sw_pdown_nxt = bus_wdata_in[0];
    end
    if (wr_div) begin
      div_nxt = bus_wdata_in;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_r    <= 1'b0;
      sel_r       <= 2'b00;
      irq_mask_r  <= 2'b00;
      irq_level_r <= `ACC_IRQ_LEVEL_RST;
      sw_pdown_r  <= 1'b0;
      div_r       <= `ACC_SCLK_DIV_RST;
    end else begin
      enable_r    <= enable_nxt;
      sel_r       <= sel_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_level_r <= irq_level_nxt;
      sw_pdown_r  <= sw_pdown_nxt;
      div_r       <= div_nxt;
    end
  end

  // Sticky status per event: the set beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_evt
      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (evt_clr[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Read data stand for the one cycle after the read strobe, zero otherwise
  always @* begin
    rdata_nxt = 8'h00;
    if (bus_rd_in) begin
      case (1'b1)
        hit_ctrl:   rdata_nxt = ctrl_view;
        hit_result: rdata_nxt = result_r;
        hit_stat:   rdata_nxt = {6'h00, irq_stat_r};
        hit_mask:   rdata_nxt = {6'h00, irq_mask_r};
        hit_level:  rdata_nxt = {5'h00, irq_level_r};
        hit_pdown:  rdata_nxt = {7'h00, sw_pdown_r};
        hit_div:    rdata_nxt = div_r;
        default:    rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_rdata_out <= 8'h00;
    end else begin
      bus_rdata_out <= rdata_nxt;
    end
  end

  // Output next values
  always @* begin
    sel_out_nxt    = sel_r;
    enable_out_nxt = enable_r;
    ref_on_nxt     = enable_r && !pdown;
    sample_nxt     = converting && !abort;
    irq_nxt        = irq_pending;
  end

  // Every output comes straight from its own flop
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_select_field_out <= 2'b00;
    end else begin
      input_select_field_out <= sel_out_nxt;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      converter_enable_bit_out <= 1'b0;
    end else begin
      converter_enable_bit_out <= enable_out_nxt;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reference_on_out <= 1'b0;
    end else begin
      reference_on_out <= ref_on_nxt;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sar_sample_out <= 1'b0;
    end else begin
      sar_sample_out <= sample_nxt;
    end
  end

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_nxt;
    end
  end

endmodule // acc_adc_control
`default_nettype wire

// >>> acc_consts.vh
// Register offsets, field positions and timing constants of the converter control block
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_ADDR_W          32
`define ACC_CTRL_ADDR       32'hFFFF_8807
`define ACC_RESULT_ADDR     32'hFFFF_8809
`define ACC_IRQ_STAT_ADDR   32'hFFFF_8811
`define ACC_IRQ_MASK_ADDR   32'hFFFF_8813
`define ACC_IRQ_LEVEL_ADDR  32'hFFFF_8815
`define ACC_PDOWN_ADDR      32'hFFFF_8817
`define ACC_SCLK_DIV_ADDR   32'hFFFF_8819
`define ACC_SEL_LSB         0
`define ACC_SEL_MSB         1
`define ACC_BUSY_BIT        3
`define ACC_DONE_BIT        4
`define ACC_EN_BIT          6
`define ACC_CONV_PERIODS    8'h18
`define ACC_SCLK_DIV_RST    8'h01
`define ACC_IRQ_LEVEL_RST   3'h0
`define ACC_IRQ_DONE_BIT    0
`define ACC_IRQ_ABORT_BIT   1
`endif

// >>> acc_adc_control_checker.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module acc_adc_control_checker #(parameter CONV_PERIODS = 24) (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic        bus_wr_in,
  input wire logic        bus_rd_in,
  input wire logic [7:0]  bus_rdata_out,
  input wire logic        power_down_in,
  input wire logic [1:0]  input_select_field_out,
  input wire logic        converter_enable_bit_out,
  input wire logic        reference_on_out,
  input wire logic        sar_sample_out,
  input wire logic        irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_pd_held; power_down_in [*5]; endsequence
  sequence s_full_run; sar_sample_out [*4]; endsequence
  property p_rd_idle; !$past(bus_rd_in) |-> bus_rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read slot");
  property p_rd_unmapped;
    bus_rd_in && bus_addr_in == 32'hffff_8801 |=> bus_rdata_out == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_ref_en; reference_on_out |-> converter_enable_bit_out; endproperty
  a_ref_en: assert property (p_ref_en) else $error("reference on while disabled");
  property p_pd_ref; s_pd_held |-> !reference_on_out; endproperty
  a_pd_ref: assert property (p_pd_ref) else $error("reference on in power-down");
  property p_pd_abort; s_pd_held |-> !sar_sample_out; endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("conversion runs in power-down");
  property p_run_len;
    $rose(sar_sample_out) |-> s_full_run or ##[0:3] (power_down_in || bus_wr_in); endproperty
  a_run_len: assert property (p_run_len) else $error("conversion ended early");
  property p_sel_hold;
    sar_sample_out && $past(sar_sample_out) |-> $stable(input_select_field_out); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved while busy");
  property p_en_run; !converter_enable_bit_out [*2] |-> !sar_sample_out; endproperty
  a_en_run: assert property (p_en_run) else $error("conversion while disabled");
endmodule // acc_adc_control_checker
bind acc_adc_control acc_adc_control_checker #(.CONV_PERIODS(CONV_PERIODS)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_addr_in(bus_addr_in),
  .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out),
  .power_down_in(power_down_in), .input_select_field_out(input_select_field_out),
  .converter_enable_bit_out(converter_enable_bit_out), .reference_on_out(reference_on_out),
  .sar_sample_out(sar_sample_out), .irq_out(irq_out));
`default_nettype wire

// >>> acc_sar_model.sv
// Behavioural converter core feeding the result lines
`timescale 1ns/1ns
`default_nettype none
module acc_sar_model (
  input  wire logic       clk_in,
  input  wire logic       sample_in,
  input  wire logic [1:0] sel_in,
  input  wire logic [7:0] level_in,
  output var  logic [7:0] data_out
);
  initial data_out = 8'h5a;
  // Outside a conversion the lines toggle so a stale value never looks valid
  always @(posedge clk_in) begin
    if (sample_in) data_out <= level_in ^ {6'h00, sel_in};
    else data_out <= ~data_out;
  end
endmodule // acc_sar_model
`default_nettype wire

// >>> acc_adc_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.vh"
module acc_adc_control_tb_top;
  logic        core_clk_in = 1'b0, rst_n_in = 1'b0, bus_wr_in = 1'b0, bus_rd_in = 1'b0;
  logic        power_down_in = 1'b0, rd_seen = 1'b0, en_out, ref_out, smp_out, irq_out;
  logic [31:0] bus_addr_in = 32'h0000_0000;
  logic [7:0]  bus_wdata_in = 8'h00, bus_rdata_out, sar_data_in, level = 8'h00, res, exp_q[$];
  logic [1:0]  sel_out;
  int          mismatches = 0, compares = 0, n;
  always #50 core_clk_in = ~core_clk_in;
  acc_adc_control #(.CONV_PERIODS(8)) uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
    .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .power_down_in(power_down_in),
    .sar_data_in(sar_data_in), .input_select_field_out(sel_out),
    .converter_enable_bit_out(en_out), .reference_on_out(ref_out), .sar_sample_out(smp_out),
    .irq_out(irq_out));
  acc_sar_model u_sar (.clk_in(core_clk_in), .sample_in(smp_out), .sel_in(sel_out),
    .level_in(level), .data_out(sar_data_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; on a read the data argument is the expected answer
  task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    bus_addr_in <= a;
    bus_wdata_in <= d;
    bus_wr_in <= wr;
    bus_rd_in <= !wr;
    if (!wr) exp_q.push_back(d);
    @(posedge core_clk_in);
    bus_wr_in <= 1'b0;
    bus_rd_in <= 1'b0;
  endtask
  task automatic idle;
    n = 0;
    repeat (2) @(posedge core_clk_in);
    while (smp_out !== 1'b0 && n < 100) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 100) mismatches++;
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk_in) rd_seen <= bus_rd_in;
  always @(negedge core_clk_in) if (rd_seen) chk(bus_rdata_out, exp_q.pop_front());
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end
  initial begin
    n = $urandom(32'h073fa81d);
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    bus(0, `ACC_CTRL_ADDR, 8'h00);
    bus(0, 32'hffff_8801, 8'h00);
    bus(1, `ACC_SCLK_DIV_ADDR, 8'h00);
    bus(1, `ACC_IRQ_MASK_ADDR, 8'h01);
    for (logic [7:0] s = 8'h00; s < 8'h04; s++) begin
      res = 8'($urandom);
      level <= res;
      res = res ^ s;
      bus(1, `ACC_IRQ_LEVEL_ADDR, s);
      bus(1, `ACC_CTRL_ADDR, 8'h48 | s);
      bus(0, `ACC_CTRL_ADDR, 8'h48 | s);
      idle();
      chk({5'h00, ref_out, sel_out}, 8'h04 | s);
      chk(8'(irq_out), 8'(s != 8'h00));
      bus(0, `ACC_CTRL_ADDR, 8'h50 | s);
      bus(0, `ACC_RESULT_ADDR, res);
      level <= ~level;
      // Start, done-one and a new select while done is high: all ignored
      bus(1, `ACC_CTRL_ADDR, 8'h58 | (s ^ 8'h01));
      bus(1, `ACC_RESULT_ADDR, 8'h00);
      bus(0, `ACC_CTRL_ADDR, 8'h50 | s);
      bus(0, `ACC_RESULT_ADDR, res);
      bus(1, `ACC_CTRL_ADDR, 8'h40 | s);
      bus(1, `ACC_IRQ_STAT_ADDR, 8'h01);
      bus(0, `ACC_CTRL_ADDR, 8'h40 | s);
      @(negedge core_clk_in);
      chk({6'h00, irq_out, smp_out}, 8'h00);
    end
    bus(1, `ACC_CTRL_ADDR, 8'h4b);
    power_down_in <= 1'b1;
    repeat (6) @(negedge core_clk_in);
    chk({6'h00, smp_out, ref_out}, 8'h00);
    bus(0, `ACC_CTRL_ADDR, 8'h43);
    bus(0, `ACC_IRQ_STAT_ADDR, 8'h02);
    power_down_in <= 1'b0;
    bus(1, `ACC_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge core_clk_in);
    chk({6'h00, en_out, ref_out}, 8'h00);
    test_done();
  end
endmodule // acc_adc_control_tb_top
`default_nettype wire
